// *** logic/nua_core.sv ***
// Numeric unit state words, stack slots and the absolute value and add operations
// Contract
// - Status bits 13..11 hold the binary stack-top slot index.
// - Status bit 7 reports a pending interrupt request.
// - Detected exceptions set the matching status flag among bits 5..0.
// - Six control mask bits; a one suppresses that exception's response.
// - Interrupt gate bit: zero lets exception interrupts out, one blocks them.
// - Precision field: 00 is 24, 10 is 53, 11 is 64 bits.
// - Rounding field: nearest even, down, up, truncate.
// - Infinity control: zero projective, one affine; bit 12 is only stored, adds treat infinities as affine in both settings.
// - Two-bit class tag per slot: valid, zero, special, empty.
// - Each instruction captures its 20-bit address and opcode into pointers.
// - Only the low eleven opcode bits are stored; upper five are fixed.
// - Sources stay unchanged; only the destination takes the result.
// - Results between representable values round by the selected mode.
// - Absolute value clears the top sign in 14 clocks; only invalid.
// - Real add: 85 between slots, 105 or 110 plus address time.
// - Add-and-pop 90 clocks; integer add 120 or 125 plus address time.
// - Adds raise invalid, denormal, overflow, underflow, precision, never zero divide.
// - Status bit 15 is high while executing, low while idle.
// - Condition code lives in status bits 14 and 10..8.
// - Push decrements the index then writes; pop reads then increments.
`timescale 1ns/1ps
`default_nettype none
module nua_core #(
   parameter int SLOTS = nua_pkg::SLOT_N
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic start_in,
   input wire logic [2:0] op_in,
   input wire logic [1:0] src_kind_in,
   input wire logic [2:0] rel_slot_in,
   input wire logic to_rel_in,
   input wire logic [79:0] mem_data_in,
   input wire logic [7:0] address_calc_cycles_in,
   input wire logic [15:0] opcode_in,
   input wire logic [19:0] instr_addr_in,
   input wire logic [19:0] operand_addr_in,
   input wire logic cw_wr_in,
   input wire logic [15:0] cw_data_in,
   input wire logic clear_exc_in,
   input wire logic [3:0] cond_in,
   input wire logic cond_wr_in,
   input wire logic [2:0] rd_slot_in,
   output logic [15:0] numeric_condition_word_out,
   output logic [15:0] numeric_option_word_out,
   output logic [15:0] slot_class_word_out,
   output logic [19:0] faulting_operand_addr_out,
   output logic [10:0] faulting_opcode_out,
   output logic [19:0] faulting_instr_addr_out,
   output logic [79:0] rd_data_out,
   output logic irq_out,
   output logic busy_out
);
   typedef struct packed {
      logic [SLOTS-1:0][79:0] slot;
      logic [SLOTS-1:0][1:0] tag;
      logic [2:0] top;
      logic [3:0] cc;
      logic irq;
      logic [5:0] exc;
      logic [15:0] cw;
      logic [19:0] op_addr;
      logic [10:0] opc;
      logic [19:0] in_addr;
      logic busy;
      logic [8:0] cnt;
      logic [2:0] op;
      logic [2:0] dst;
      logic [79:0] res;
      logic [5:0] pend;
      logic pop;
      logic [79:0] rd;
      logic irq_o;
   } nua_state_t;
   nua_state_t st_r, st_nxt;
   logic [79:0] src_val, dst_val, add_a, add_b, add_sum, ival;
   logic [5:0] add_exc, pend_sum, unmasked;
   logic [2:0] top_slot, rel_idx;
   logic [31:0] imag;
   logic [6:0] ilz;
   int k;

   function automatic logic [1:0] class_of(input logic [79:0] v);
      if (v[78:64] == 15'h7fff || (v[78:64] == 15'h0 && v[63:0] != 64'h0)) class_of = nua_pkg::TAG_SPECIAL;
      else if (v[78:0] == 79'h0) class_of = nua_pkg::TAG_ZERO;
      else class_of = nua_pkg::TAG_VALID;
   endfunction

   function automatic logic [8:0] cycles_of(input logic [2:0] op, input logic [1:0] sk, input logic [7:0] ea);
      case (nua_pkg::nua_op_t'(op))
         nua_pkg::NUA_OP_ABS: cycles_of = {1'b0, nua_pkg::CYC_ABS};
         nua_pkg::NUA_OP_ADD_POP: cycles_of = {1'b0, nua_pkg::CYC_ADD_POP};
         nua_pkg::NUA_OP_IADD: cycles_of = (sk == nua_pkg::NUA_SRC_WORD) ? {1'b0, nua_pkg::CYC_IADD_WORD} + {1'b0, ea}
                                                                         : {1'b0, nua_pkg::CYC_IADD_SHORT} + {1'b0, ea};
         nua_pkg::NUA_OP_ADD: begin
            case (nua_pkg::nua_src_t'(sk))
               nua_pkg::NUA_SRC_SHORT: cycles_of = {1'b0, nua_pkg::CYC_ADD_SHORT} + {1'b0, ea};
               nua_pkg::NUA_SRC_LONG: cycles_of = {1'b0, nua_pkg::CYC_ADD_LONG} + {1'b0, ea};
               default: cycles_of = {1'b0, nua_pkg::CYC_ADD_REG};
            endcase
         end
         default: cycles_of = 9'd1;
      endcase
   endfunction

   nua_adder u_adder (
      .a_in(add_a),
      .b_in(add_b),
      .prec_in(st_r.cw[9:8]),
      .mode_in(st_r.cw[11:10]),
      .sum_out(add_sum),
      .exc_out(add_exc)
   );

   always_comb begin
      st_nxt = st_r;
      // Clear first so a flag raised in the same cycle still lands
      if (clear_exc_in) begin
         st_nxt.exc = 6'h0;
         st_nxt.irq = 1'b0;
      end
      top_slot = st_r.top;
      rel_idx = st_r.top + rel_slot_in;
      // Integer operand converted to extended real; exact for 32 bits
      imag = mem_data_in[31] ? 32'(-mem_data_in[31:0]) : mem_data_in[31:0];
      if (src_kind_in == nua_pkg::NUA_SRC_WORD) imag = mem_data_in[15] ? 32'(16'(-mem_data_in[15:0])) : {16'h0, mem_data_in[15:0]};
      ilz = 7'd0;
      for (k = 0; k < 32; k++) begin
         if (imag[k]) ilz = 7'(31 - k);
      end
      ival = (imag == 32'h0) ? 80'h0 : {(src_kind_in == nua_pkg::NUA_SRC_WORD) ? mem_data_in[15] : mem_data_in[31],
              15'(16'h3fff + 16'd31 - {9'h0, ilz}), 64'({imag << ilz, 32'h0})};
      src_val = (src_kind_in == nua_pkg::NUA_SRC_SLOT) ? st_r.slot[rel_idx] : mem_data_in;
      if (op_in == nua_pkg::NUA_OP_IADD) src_val = ival;
      dst_val = st_r.slot[top_slot];
      add_a = st_r.res;
      add_b = st_r.slot[st_r.dst];
      pend_sum = st_r.pend | add_exc;
      unmasked = pend_sum & ~st_r.cw[5:0];
      if (!st_r.busy && start_in) begin
         st_nxt.in_addr = instr_addr_in;
         st_nxt.op_addr = operand_addr_in;
         st_nxt.opc = opcode_in[10:0];
         st_nxt.busy = 1'b1;
         st_nxt.op = op_in;
         st_nxt.pend = 6'h0;
         st_nxt.pop = (op_in == nua_pkg::NUA_OP_ADD_POP);
         st_nxt.cnt = cycles_of(op_in, src_kind_in, address_calc_cycles_in) - 9'd1;
         st_nxt.res = src_val;
         st_nxt.dst = (to_rel_in || op_in == nua_pkg::NUA_OP_ADD_POP) ? rel_idx : top_slot;
         if (op_in == nua_pkg::NUA_OP_ADD_POP || (op_in == nua_pkg::NUA_OP_ADD && to_rel_in)) st_nxt.res = dst_val;
         if (op_in == nua_pkg::NUA_OP_ABS) begin
            st_nxt.dst = top_slot;
            st_nxt.res = {1'b0, dst_val[78:0]};
            // only invalid, on an empty top
            st_nxt.pend[nua_pkg::EX_INV] = (st_r.tag[top_slot] == nua_pkg::TAG_EMPTY);
         end else if (op_in == nua_pkg::NUA_OP_PUSH) begin
            // push decrements first, wrapping modulo eight
            st_nxt.top = st_r.top - 3'd1;
            st_nxt.dst = st_r.top - 3'd1;
            st_nxt.res = mem_data_in;
         end else if (op_in == nua_pkg::NUA_OP_POP) begin
            st_nxt.rd = dst_val;
            st_nxt.pop = 1'b1;
         end
      end else if (st_r.busy) begin
         st_nxt.cnt = st_r.cnt - 9'd1;
         if (st_r.cnt == 9'd0) begin
            st_nxt.busy = 1'b0;
            // only the destination slot is written
            if (st_r.op == nua_pkg::NUA_OP_POP) begin
               st_nxt.tag[st_r.top] = nua_pkg::TAG_EMPTY;
            end else if (st_r.op == nua_pkg::NUA_OP_ABS || st_r.op == nua_pkg::NUA_OP_PUSH) begin
               if (!st_r.pend[nua_pkg::EX_INV]) begin
                  st_nxt.slot[st_r.dst] = st_r.res;
                  st_nxt.tag[st_r.dst] = class_of(st_r.res);
               end
            end else begin
               // masked exceptions still deliver the result
               if ((unmasked & 6'h1b) == 6'h0) begin
                  st_nxt.slot[st_r.dst] = add_sum;
                  st_nxt.tag[st_r.dst] = class_of(add_sum);
               end
            end
            if (st_r.op <= nua_pkg::NUA_OP_IADD) st_nxt.exc = st_nxt.exc | ((st_r.op == nua_pkg::NUA_OP_ABS) ? st_r.pend : pend_sum);
            // request raised for an unmasked exception
            if (((st_r.op == nua_pkg::NUA_OP_ABS) ? (st_r.pend & ~st_r.cw[5:0]) : unmasked) != 6'h0) st_nxt.irq = 1'b1;
            if (st_r.pop) begin
               st_nxt.top = st_r.top + 3'd1;
               if (st_r.op == nua_pkg::NUA_OP_ADD_POP) st_nxt.tag[st_r.top] = nua_pkg::TAG_EMPTY;
            end
         end
      end
      if (cond_wr_in) st_nxt.cc = cond_in;
      if (cw_wr_in) st_nxt.cw = cw_data_in & nua_pkg::CW_WRITE_MASK;
      st_nxt.irq_o = st_nxt.irq && !st_nxt.cw[nua_pkg::CW_IEM_BIT];
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
         st_r.tag <= '1;
         st_r.cw <= nua_pkg::CW_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // tags packed two bits per slot
   always_comb begin
      for (int j = 0; j < SLOTS; j++) slot_class_word_out[2*j +: 2] = st_r.tag[j];
   end
   assign numeric_condition_word_out = {st_r.busy, st_r.cc[3], st_r.top, st_r.cc[2:0], st_r.irq, 1'b0, st_r.exc};
   // fields held in the option word
   assign numeric_option_word_out = st_r.cw;
   assign faulting_operand_addr_out = st_r.op_addr;
   assign faulting_opcode_out = st_r.opc;
   assign faulting_instr_addr_out = st_r.in_addr;
   assign rd_data_out = st_r.rd;
   assign irq_out = st_r.irq_o;
   assign busy_out = st_r.busy;

   a_busy_abs: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (start_in && !busy_out && op_in == 3'h0) |=> busy_out [*8] ##1 busy_out [*6] ##1 !busy_out)
      else $error("absolute value busy length wrong");
   a_busy_addreg: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (start_in && !busy_out && op_in == 3'h1 && src_kind_in == 2'h0) |=> ##84 busy_out ##1 !busy_out)
      else $error("register add duration wrong");
   a_busy_pop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (start_in && !busy_out && op_in == 3'h2) |=> ##89 busy_out ##1 !busy_out)
      else $error("add and pop duration wrong");
   a_abs_sign: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (busy_out && st_r.op == 3'h0 && st_r.cnt == 9'd0 && !st_r.pend[0]) |=> !st_r.slot[$past(st_r.dst)][79])
      else $error("absolute value left sign set");
   a_push_top: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (start_in && !busy_out && op_in == 3'h4) |=> numeric_condition_word_out[13:11] == $past(st_r.top) - 3'd1)
      else $error("push did not decrement index");
   a_opc_capture: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (start_in && !busy_out) |=> faulting_opcode_out == $past(opcode_in[10:0]))
      else $error("opcode not captured");
   a_irq_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      irq_out |-> numeric_condition_word_out[7] && !numeric_option_word_out[7])
      else $error("interrupt passed closed gate");
   a_no_zdiv: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (!numeric_condition_word_out[2] && !clear_exc_in) |=> !numeric_condition_word_out[2])
      else $error("add raised zero divide");
   a_cw_resv: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (numeric_option_word_out & 16'he_040) == 16'h0_000)
      else $error("reserved control bit set");
endmodule
`default_nettype wire

// *** logic/nua_pkg.sv ***
// Shared constants and types for the numeric unit state and add block
package nua_pkg;
   localparam int EXP_W = 15;
   localparam int SIG_W = 64;
   localparam int SLOT_W = 80;
   localparam int SLOT_N = 8;
   localparam int ADDR_W = 20;
   localparam int OPC_W = 11;
   // Status word fields
   localparam int SW_BUSY_BIT = 15;
   localparam int SW_C3_BIT = 14;
   localparam int SW_TOP_HI = 13;
   localparam int SW_TOP_LO = 11;
   localparam int SW_C2_BIT = 10;
   localparam int SW_C0_BIT = 8;
   localparam int SW_IRQ_BIT = 7;
   localparam int SW_EXC_HI = 5;
   // Control word fields
   localparam int CW_IC_BIT = 12;
   localparam int CW_RC_LO = 10;
   localparam int CW_PC_LO = 8;
   localparam int CW_IEM_BIT = 7;
   localparam logic [15:0] CW_WRITE_MASK = 16'h1_fbf;
   localparam logic [15:0] CW_RESET = 16'h0_3bf;
   localparam logic [4:0] OPC_HOOK = 5'h1b;
   // Exception flag positions
   localparam int EX_INV = 0;
   localparam int EX_DEN = 1;
   localparam int EX_ZDV = 2;
   localparam int EX_OVF = 3;
   localparam int EX_UNF = 4;
   localparam int EX_PRE = 5;
   // Typical execution counts
   localparam logic [7:0] CYC_ABS = 8'd14;
   localparam logic [7:0] CYC_ADD_REG = 8'd85;
   localparam logic [7:0] CYC_ADD_SHORT = 8'd105;
   localparam logic [7:0] CYC_ADD_LONG = 8'd110;
   localparam logic [7:0] CYC_ADD_POP = 8'd90;
   localparam logic [7:0] CYC_IADD_WORD = 8'd120;
   localparam logic [7:0] CYC_IADD_SHORT = 8'd125;
   // Tag codes
   localparam logic [1:0] TAG_VALID = 2'h0;
   localparam logic [1:0] TAG_ZERO = 2'h1;
   localparam logic [1:0] TAG_SPECIAL = 2'h2;
   localparam logic [1:0] TAG_EMPTY = 2'h3;
   typedef enum logic [2:0] {
      NUA_OP_ABS = 3'h0, NUA_OP_ADD = 3'h1, NUA_OP_ADD_POP = 3'h2, NUA_OP_IADD = 3'h3,
      NUA_OP_PUSH = 3'h4, NUA_OP_POP = 3'h5
   } nua_op_t;
   typedef enum logic [1:0] {
      NUA_SRC_SLOT = 2'h0, NUA_SRC_SHORT = 2'h1, NUA_SRC_LONG = 2'h2, NUA_SRC_WORD = 2'h3
   } nua_src_t;
   typedef enum logic [1:0] {
      NUA_RND_NEAR = 2'h0, NUA_RND_DOWN = 2'h1, NUA_RND_UP = 2'h2, NUA_RND_CHOP = 2'h3
   } nua_rnd_t;
endpackage

// *** logic/nua_round.sv ***
// Rounds an extended significand to the selected precision and mode
`timescale 1ns/1ps
`default_nettype none
module nua_round (
   input wire logic sign_in,
   input wire logic [66:0] sig_in,
   input wire logic [1:0] prec_in,
   input wire logic [1:0] mode_in,
   output logic [64:0] sig_out,
   output logic inexact_out
);
   logic [66:0] lsb;
   logic [66:0] keep_mask;
   logic [66:0] kept;
   logic [66:0] rest;
   logic [66:0] half;
   logic up;
   logic [67:0] sum;
   always_comb begin
      case (prec_in)
         2'h0: lsb = 67'h1 << 43;
         2'h2: lsb = 67'h1 << 14;
         default: lsb = 67'h1 << 3;
      endcase
      keep_mask = ~(lsb - 67'h1);
      kept = sig_in & keep_mask;
      rest = sig_in & ~keep_mask;
      half = lsb >> 1;
      inexact_out = (rest != 67'h0);
      case (nua_pkg::nua_rnd_t'(mode_in))
         nua_pkg::NUA_RND_NEAR: up = (rest > half) || ((rest == half) && ((kept & lsb) != 67'h0));
         nua_pkg::NUA_RND_DOWN: up = inexact_out && sign_in;
         nua_pkg::NUA_RND_UP: up = inexact_out && !sign_in;
         default: up = 1'b0;
      endcase
      sum = {1'b0, kept} + (up ? {1'b0, lsb} : 68'h0);
      sig_out = sum[67:3];
   end
endmodule
`default_nettype wire

// *** logic/nua_adder.sv ***
// Extended real adder with alignment, normalisation and rounding
`timescale 1ns/1ps
`default_nettype none
module nua_adder (
   input wire logic [79:0] a_in,
   input wire logic [79:0] b_in,
   input wire logic [1:0] prec_in,
   input wire logic [1:0] mode_in,
   output logic [79:0] sum_out,
   output logic [5:0] exc_out
);
   logic [14:0] ea, eb, el;
   logic [66:0] ma, mb, ml, ms, mag;
   logic [67:0] raw;
   logic sl, ss, sres, inexact, spec;
   logic [14:0] diff, eres;
   logic [64:0] rnd;
   logic [6:0] lz;
   int i;
   nua_round u_round (
      .sign_in(sres),
      .sig_in(mag),
      .prec_in(prec_in),
      .mode_in(mode_in),
      .sig_out(rnd),
      .inexact_out(inexact)
   );
   always_comb begin
      ea = a_in[78:64];
      eb = b_in[78:64];
      ma = {a_in[63:0], 3'h0};
      mb = {b_in[63:0], 3'h0};
      spec = (ea == 15'h7fff) || (eb == 15'h7fff);
      if (ea >= eb) begin
         el = ea; diff = ea - eb; ml = ma; ms = mb; sl = a_in[79]; ss = b_in[79];
      end else begin
         el = eb; diff = eb - ea; ml = mb; ms = ma; sl = b_in[79]; ss = a_in[79];
      end
      // Sticky bit collects only the bits shifted out, else exact sums look inexact
      ms = (diff > 15'd66) ? {66'h0, |ms} : ((ms >> diff) | {66'h0, |(ms & (67'h7_ffff_ffff_ffff_ffff >> (15'd67 - diff)))});
      if (sl == ss) raw = {1'b0, ml} + {1'b0, ms};
      else if (ml >= ms) raw = {1'b0, ml - ms};
      else raw = {1'b0, ms - ml};
      sres = (sl == ss || ml >= ms) ? sl : ss;
      lz = 7'd0;
      // Last hit is the leading one, so no variable slice is needed
      for (i = 0; i <= 66; i++) begin
         if (raw[i]) lz = 7'(66 - i);
      end
      eres = el;
      if (raw[67]) begin
         mag = raw[67:1] | {66'h0, raw[0]};
         eres = el + 15'd1;
      end else if (raw[66:0] == 67'h0) begin
         mag = 67'h0; eres = 15'h0; sres = (mode_in == 2'h1) && (sl != ss);
      end else begin
         mag = raw[66:0] << lz;
         eres = (el > 15'(lz)) ? el - 15'(lz) : 15'h0;
      end
      exc_out = 6'h0;
      sum_out = {sres, eres, rnd[63:0]};
      if (rnd[64]) sum_out = {sres, eres + 15'd1, 1'b1, rnd[63:1]};
      exc_out[nua_pkg::EX_PRE] = inexact;
      exc_out[nua_pkg::EX_DEN] = (ea == 15'h0 && a_in[63]) || (eb == 15'h0 && b_in[63]);
      exc_out[nua_pkg::EX_OVF] = (sum_out[78:64] == 15'h7fff) && !spec;
      exc_out[nua_pkg::EX_UNF] = (eres == 15'h0) && (mag != 67'h0);
      if (spec) begin
         exc_out[nua_pkg::EX_INV] = (a_in[79] != b_in[79]) && (ea == 15'h7fff) && (eb == 15'h7fff);
         sum_out = (ea == 15'h7fff) ? a_in : b_in;
         exc_out[nua_pkg::EX_PRE] = 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** verif/nua_host_model.sv ***
// Host model that issues numeric instructions and waits out the busy flag
`timescale 1ns/1ps
`default_nettype none
module nua_host_model (
   input wire logic clk_in,
   input wire logic busy_in,
   output logic start_out,
   output logic [2:0] op_out,
   output logic [1:0] src_out,
   output logic [2:0] rel_out,
   output logic [79:0] data_out,
   output logic [7:0] ea_out,
   output logic [15:0] opc_out,
   output logic [19:0] iaddr_out,
   output logic [19:0] oaddr_out
);
   initial begin
      start_out = 1'b0;
      op_out = 3'h0;
      src_out = 2'h0;
      rel_out = 3'h0;
      data_out = 80'h0;
      ea_out = 8'h00;
      opc_out = 16'h0000;
      iaddr_out = 20'h0_0000;
      oaddr_out = 20'h0_0000;
   end
   // Request held until the taking edge; never issued while busy
   task automatic issue(input logic [2:0] op, input logic [1:0] src, input logic [2:0] rel,
      input logic [79:0] d, input logic [7:0] ea, output int cyc);
      cyc = 0;
      @(posedge clk_in);
      start_out <= 1'b1;
      op_out <= op;
      src_out <= src;
      rel_out <= rel;
      data_out <= d;
      ea_out <= ea;
      opc_out <= {5'h1b, 8'h00, op};
      iaddr_out <= {4'h5, 5'h1b, 8'h00, op};
      oaddr_out <= {4'h3, ~{5'h1b, 8'h00, op}};
      @(posedge clk_in);
      start_out <= 1'b0;
      // Operand bus driven to the inverted value, so it stops showing the old value
      data_out <= ~d;
      #1;
      while (busy_in === 1'b1 && cyc < 400) begin
         @(posedge clk_in);
         #1;
         cyc++;
      end
   endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the numeric unit state and add block
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [79:0] ONE = 80'h3fff_8000_0000_0000_0000;
   localparam logic [79:0] TWO = 80'h4000_8000_0000_0000_0000;
   localparam logic [79:0] THREE = 80'h4000_c000_0000_0000_0000;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic cw_wr_in = 1'b0;
   logic [15:0] cw_data_in = 16'h0000;
   logic clear_exc_in = 1'b0;
   logic [3:0] cond_in = 4'h0;
   logic cond_wr_in = 1'b0;
   logic start, irq, busy;
   logic to_rel = 1'b0;
   logic [2:0] op, rel, top = 3'h0;
   logic [1:0] src;
   logic [79:0] data, rd;
   logic [7:0] ea;
   logic [15:0] opc, sw, cw, tw;
   logic [19:0] iaddr, oaddr, foa, fia;
   logic [10:0] fop;
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;
   logic [15:0] cwv [5] = '{16'h03bf, 16'h07bf, 16'h0bbf, 16'h0fbf, 16'h08bf};
   logic [79:0] opd [5] = '{80'h3fb9_8000_0000_0000_0000, 80'h3fb9_8000_0000_0000_0000,
      80'h3fb9_8000_0000_0000_0000, 80'h3fb9_8000_0000_0000_0000, 80'h3fe1_8000_0000_0000_0000};
   logic [79:0] rex [5] = '{ONE, ONE, 80'h3fff_8000_0000_0000_0001, ONE, 80'h3fff_8000_0100_0000_0000};
   always #5 clk_in = ~clk_in;
   nua_host_model u_host (.clk_in(clk_in), .busy_in(busy), .start_out(start), .op_out(op), .src_out(src),
      .rel_out(rel), .data_out(data), .ea_out(ea), .opc_out(opc), .iaddr_out(iaddr), .oaddr_out(oaddr));
   nua_core u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start), .op_in(op),
      .src_kind_in(src), .rel_slot_in(rel), .to_rel_in(to_rel), .mem_data_in(data),
      .address_calc_cycles_in(ea), .opcode_in(opc), .instr_addr_in(iaddr), .operand_addr_in(oaddr),
      .cw_wr_in(cw_wr_in), .cw_data_in(cw_data_in), .clear_exc_in(clear_exc_in), .cond_in(cond_in),
      .cond_wr_in(cond_wr_in), .rd_slot_in(3'h0), .numeric_condition_word_out(sw),
      .numeric_option_word_out(cw), .slot_class_word_out(tw), .faulting_operand_addr_out(foa),
      .faulting_opcode_out(fop), .faulting_instr_addr_out(fia), .rd_data_out(rd), .irq_out(irq),
      .busy_out(busy));
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cmp_val(input string nm, input logic [79:0] e, input logic [79:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_cyc(input string nm, input int e, input int g);
      checked++;
      if (g != e) begin
         fail_count++;
         $display("FAIL %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic pulse(input logic wr, input logic clr, input logic [15:0] v);
      @(posedge clk_in);
      cw_wr_in <= wr;
      clear_exc_in <= clr;
      cw_data_in <= v;
      @(posedge clk_in);
      cw_wr_in <= 1'b0;
      clear_exc_in <= 1'b0;
      #1;
   endtask
   task automatic run(input logic [2:0] o, input logic [1:0] s, input logic [2:0] r, input logic [79:0] d,
      input logic [7:0] e, input int n);
      int c;
      u_host.issue(o, s, r, d, e, c);
      top = (o == 3'h4) ? top - 3'h1 : (o == 3'h5 || o == 3'h2) ? top + 3'h1 : top;
      cmp_cyc("busy length", n, c);
      cmp_val("stack top", top, sw[13:11]);
      cmp_val("opcode ptr", {8'h00, o}, fop);
      cmp_val("instr ptr", {4'h5, 5'h1b, 8'h00, o}, fia);
      cmp_val("operand ptr", {4'h3, ~{5'h1b, 8'h00, o}}, foa);
   endtask
   task automatic pop_chk(input string nm, input logic [79:0] e);
      run(3'h5, 2'h0, 3'h0, 80'h0, 8'h00, 1);
      cmp_val(nm, e, rd);
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      cmp_val("status reset", 16'h0000, sw);
      cmp_val("control reset", 16'h03bf, cw);
      cmp_val("tag reset", 16'hffff, tw);
      pulse(1'b1, 1'b0, 16'hffff);
      cmp_val("control reserved", 16'h1fbf, cw);
      pulse(1'b1, 1'b0, 16'h03bf);
      @(posedge clk_in);
      cond_in <= 4'ha;
      cond_wr_in <= 1'b1;
      @(posedge clk_in);
      cond_wr_in <= 1'b0;
      #1;
      cmp_val("condition code", 16'h4200, sw & 16'h4700);
      run(3'h4, 2'h0, 3'h0, ONE, 8'h00, 1);
      run(3'h4, 2'h0, 3'h0, 80'hc000_8000_0000_0000_0000, 8'h00, 1);
      cmp_val("tags pushed", 16'h0fff, tw);
      run(3'h0, 2'h0, 3'h0, 80'h0, 8'h00, 14);
      run(3'h1, 2'h0, 3'h1, 80'h0, 8'h00, 85);
      pop_chk("slot sum", THREE);
      cmp_val("exact flags", 8'h00, sw[7:0]);
      pop_chk("source kept", ONE);
      cmp_val("tags emptied", 16'hffff, tw);
      run(3'h4, 2'h0, 3'h0, ONE, 8'h00, 1);
      run(3'h4, 2'h0, 3'h0, TWO, 8'h00, 1);
      run(3'h2, 2'h0, 3'h1, 80'h0, 8'h00, 90);
      pop_chk("add pop sum", THREE);
      run(3'h4, 2'h0, 3'h0, ONE, 8'h00, 1);
      run(3'h3, 2'h3, 3'h0, 80'h5, 8'h04, 124);
      pop_chk("word int sum", 80'h4001_c000_0000_0000_0000);
      run(3'h4, 2'h0, 3'h0, ONE, 8'h00, 1);
      run(3'h3, 2'h0, 3'h0, 80'hffff_ffff, 8'h02, 127);
      cmp_val("zero tag", 2'h1, tw[2 * top +: 2]);
      pop_chk("short int sum", 80'h0);
      run(3'h4, 2'h0, 3'h0, ONE, 8'h00, 1);
      run(3'h1, 2'h2, 3'h0, TWO, 8'h00, 110);
      pop_chk("long real sum", THREE);
      // Destination is the relative slot; the top stays as it was
      run(3'h4, 2'h0, 3'h0, ONE, 8'h00, 1);
      run(3'h4, 2'h0, 3'h0, TWO, 8'h00, 1);
      @(posedge clk_in);
      to_rel <= 1'b1;
      run(3'h1, 2'h0, 3'h1, 80'h0, 8'h00, 85);
      @(posedge clk_in);
      to_rel <= 1'b0;
      pop_chk("top kept", TWO);
      pop_chk("rel sum", THREE);
      for (int i = 0; i < 5; i++) begin
         pulse(1'b1, 1'b0, cwv[i]);
         run(3'h4, 2'h0, 3'h0, ONE, 8'h00, 1);
         run(3'h1, 2'h1, 3'h0, opd[i], 8'h03, 108);
         pop_chk("rounded sum", rex[i]);
         cmp_val("inexact flags", 8'h20, sw[7:0]);
      end
      // Unmasked inexact raises the request; the gate then blocks it
      pulse(1'b0, 1'b1, 16'h0000);
      pulse(1'b1, 1'b0, 16'h031f);
      run(3'h4, 2'h0, 3'h0, ONE, 8'h00, 1);
      run(3'h1, 2'h1, 3'h0, opd[0], 8'h03, 108);
      cmp_val("request flag", 8'ha0, sw[7:0]);
      cmp_val("irq open", 1'b1, irq);
      pulse(1'b1, 1'b0, 16'h039f);
      cmp_val("irq gated", 1'b0, irq);
      pulse(1'b0, 1'b1, 16'h0000);
      cmp_val("flags cleared", 8'h00, sw[7:0]);
      close_out();
   end
endmodule
`default_nettype wire
